// [pkg/dscg_pkg.sv]
package dscg_pkg;

  // Register byte offsets; run and sleep copies sit at offsets chosen for this block
  localparam logic [11:0] RUN_GATE_OFS = 12'h104;
  localparam logic [11:0] SLEEP_GATE_OFS = 12'h114;
  localparam logic [11:0] DEEP_GATE_OFS = 12'h124;
  localparam logic [11:0] RUN_CFG_OFS = 12'h060;
  localparam logic [11:0] IRQ_STAT_OFS = 12'h200;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h204;

  // Gate bit positions
  localparam int COMP_BIT = 24;
  localparam int TMRC_BIT = 18;
  localparam int TMRB_BIT = 17;
  localparam int TMRA_BIT = 16;
  localparam int ENC_BIT = 8;
  localparam int SSP_BIT = 4;
  localparam int UARTB_BIT = 1;
  localparam int UARTA_BIT = 0;

  // Writable bits of a gating register; everything else is reserved
  localparam logic [31:0] GATE_WMASK = 32'h0107_0113;
  localparam logic [31:0] GATE_RESET = 32'h0000_0000;

  // Auto gate select position in the run clock config register
  localparam int AUTO_GATE_BIT = 27;
  localparam logic [31:0] RUN_CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] RUN_CFG_WMASK = 32'h0800_0000;

  // Interrupt status bits
  localparam int IRQ_FAULT_BIT = 0;
  localparam int IRQ_MODE_BIT = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Number of controlled units, one index per gate bit
  localparam int NUM_UNITS = 8;

  typedef enum logic [1:0] {
    DSCG_RUN,
    DSCG_SLEEP,
    DSCG_DEEP
  } dscg_mode_e;

  // One peripheral access request as seen by the fault checker
  typedef struct packed {
    logic valid;
    logic [2:0] unit;
  } dscg_access_s;

endpackage

// [verilog/dscg_top.sv]
`timescale 1ns/1ps
module dscg_top (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic SLEEP_REQ,
  input wire logic DEEP_SLEEP_REQ,
  input wire logic UNIT_ACC_VALID,
  input wire logic [2:0] UNIT_ACC_SEL,
  output logic UNIT_ACC_FAULT,
  output logic [7:0] UNIT_CLK_EN,
  output logic IRQ
);

  logic [31:0] run_gate_q;
  logic [31:0] sleep_gate_q;
  logic [31:0] deep_gate_q;
  logic [31:0] run_cfg_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic [31:0] active_gate;
  logic [7:0] unit_en;
  logic [7:0] clk_en_q;
  dscg_pkg::dscg_mode_e mode_q;
  dscg_pkg::dscg_mode_e mode_d;
  dscg_pkg::dscg_access_s acc;

  // AXI write channel state
  logic aw_got_q;
  logic w_got_q;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire;
  logic [31:0] wmask;
  logic wr_hit;

  // AXI read channel state
  logic rd_fire;
  logic [11:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_hit;
  logic stat_read;

  // Fault and mode events
  logic fault_evt;
  logic mode_evt;

  assign acc.valid = UNIT_ACC_VALID;
  assign acc.unit = UNIT_ACC_SEL;

  // Power mode follows the requests; deep sleep takes priority over sleep
  always_comb begin
    if (DEEP_SLEEP_REQ) begin
      mode_d = dscg_pkg::DSCG_DEEP;
    end else if (SLEEP_REQ) begin
      mode_d = dscg_pkg::DSCG_SLEEP;
    end else begin
      mode_d = dscg_pkg::DSCG_RUN;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      mode_q <= dscg_pkg::DSCG_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Select the copy in force; without auto gate the run copy always rules
  always_comb begin
    active_gate = run_gate_q;
    if (run_cfg_q[dscg_pkg::AUTO_GATE_BIT]) begin
      unique case (mode_q)
        dscg_pkg::DSCG_RUN: active_gate = run_gate_q;
        dscg_pkg::DSCG_SLEEP: active_gate = sleep_gate_q;
        dscg_pkg::DSCG_DEEP: active_gate = deep_gate_q;
        default: active_gate = run_gate_q;
      endcase
    end
  end

  // Map the sparse gate bits onto one enable per unit
  assign unit_en[0] = active_gate[dscg_pkg::UARTA_BIT];
  assign unit_en[1] = active_gate[dscg_pkg::UARTB_BIT];
  assign unit_en[2] = active_gate[dscg_pkg::SSP_BIT];
  assign unit_en[3] = active_gate[dscg_pkg::ENC_BIT];
  assign unit_en[4] = active_gate[dscg_pkg::TMRA_BIT];
  assign unit_en[5] = active_gate[dscg_pkg::TMRB_BIT];
  assign unit_en[6] = active_gate[dscg_pkg::TMRC_BIT];
  assign unit_en[7] = active_gate[dscg_pkg::COMP_BIT];

  // Enables change only at a clock edge, so a downstream latch-based clock
  // gate sees a stable enable through the low phase and never glitches
  genvar gi;
  generate
    for (gi = 0; gi < dscg_pkg::NUM_UNITS; gi++) begin : g_en
      always_ff @(posedge CLK_SYS) begin
        if (RST) begin
          clk_en_q[gi] <= 1'b0;
        end else begin
          clk_en_q[gi] <= unit_en[gi];
        end
      end
    end
  endgenerate
  assign UNIT_CLK_EN = clk_en_q;

  // Fault an access whose unit currently has no clock
  assign fault_evt = acc.valid && !clk_en_q[acc.unit];
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      UNIT_ACC_FAULT <= 1'b0;
    end else begin
      UNIT_ACC_FAULT <= fault_evt;
    end
  end

  assign mode_evt = (mode_q != mode_d);

  // Write side: address and data are taken independently, in either order
  assign wr_fire = aw_got_q && w_got_q && !S_AXI_BVALID;
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      aw_got_q <= 1'b0;
      aw_addr_q <= 12'h000;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_got_q <= 1'b1;
      aw_addr_q <= S_AXI_AWADDR[11:0];
    end else if (wr_fire) begin
      aw_got_q <= 1'b0;
    end
  end

  // Data and strobes wait here until the address has arrived too
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      w_got_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_got_q <= 1'b1;
      w_data_q <= S_AXI_WDATA;
      w_strb_q <= S_AXI_WSTRB;
    end else if (wr_fire) begin
      w_got_q <= 1'b0;
    end
  end

  // Ready is a flop so the outputs stay registered; one write at a time
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      S_AXI_AWREADY <= 1'b0;
    end else begin
      S_AXI_AWREADY <= !aw_got_q && !(S_AXI_AWVALID && S_AXI_AWREADY) && !S_AXI_BVALID;
    end
  end

  // Data ready mirrors address ready, so a held word is never overwritten
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      S_AXI_WREADY <= 1'b0;
    end else begin
      S_AXI_WREADY <= !w_got_q && !(S_AXI_WVALID && S_AXI_WREADY) && !S_AXI_BVALID;
    end
  end

  // Byte strobes expand to a bit mask
  generate
    for (gi = 0; gi < 4; gi++) begin : g_strb
      assign wmask[gi*8 +: 8] = {8{w_strb_q[gi]}};
    end
  endgenerate

  assign wr_hit = (aw_addr_q == dscg_pkg::RUN_GATE_OFS) ||
                  (aw_addr_q == dscg_pkg::SLEEP_GATE_OFS) ||
                  (aw_addr_q == dscg_pkg::DEEP_GATE_OFS) ||
                  (aw_addr_q == dscg_pkg::RUN_CFG_OFS) ||
                  (aw_addr_q == dscg_pkg::IRQ_STAT_OFS) ||
                  (aw_addr_q == dscg_pkg::IRQ_MASK_OFS);

  // Write response; unmapped addresses get SLVERR
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= dscg_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= wr_hit ? dscg_pkg::RESP_OKAY : dscg_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Run copy: only documented bits take writes
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      run_gate_q <= dscg_pkg::GATE_RESET;
    end else if (wr_fire && aw_addr_q == dscg_pkg::RUN_GATE_OFS) begin
      run_gate_q <= (run_gate_q & ~(wmask & dscg_pkg::GATE_WMASK)) |
                    (w_data_q & wmask & dscg_pkg::GATE_WMASK);
    end
  end

  // Sleep copy, same layout; it only acts once auto gate is set
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      sleep_gate_q <= dscg_pkg::GATE_RESET;
    end else if (wr_fire && aw_addr_q == dscg_pkg::SLEEP_GATE_OFS) begin
      sleep_gate_q <= (sleep_gate_q & ~(wmask & dscg_pkg::GATE_WMASK)) |
                      (w_data_q & wmask & dscg_pkg::GATE_WMASK);
    end
  end

  // Deep-sleep copy; reserved bits never store, so they read back zero
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      deep_gate_q <= dscg_pkg::GATE_RESET;
    end else if (wr_fire && aw_addr_q == dscg_pkg::DEEP_GATE_OFS) begin
      deep_gate_q <= (deep_gate_q & ~(wmask & dscg_pkg::GATE_WMASK)) |
                     (w_data_q & wmask & dscg_pkg::GATE_WMASK);
    end
  end

  // Run clock config holds only the auto gate select bit here
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      run_cfg_q <= dscg_pkg::RUN_CFG_RESET;
    end else if (wr_fire && aw_addr_q == dscg_pkg::RUN_CFG_OFS) begin
      run_cfg_q <= (run_cfg_q & ~(wmask & dscg_pkg::RUN_CFG_WMASK)) |
                   (w_data_q & wmask & dscg_pkg::RUN_CFG_WMASK);
    end
  end

  // Interrupt mask; a write without the low byte strobe leaves it alone
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      irq_mask_q <= dscg_pkg::IRQ_RESET;
    end else if (wr_fire && aw_addr_q == dscg_pkg::IRQ_MASK_OFS && w_strb_q[0]) begin
      irq_mask_q <= w_data_q[1:0];
    end
  end

  // Read side: one read at a time, answered the cycle after the address
  assign rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;
  assign rd_addr = S_AXI_ARADDR[11:0];
  always_comb begin
    rd_hit = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (rd_addr)
      dscg_pkg::RUN_GATE_OFS: rd_data = run_gate_q;
      dscg_pkg::SLEEP_GATE_OFS: rd_data = sleep_gate_q;
      dscg_pkg::DEEP_GATE_OFS: rd_data = deep_gate_q;
      dscg_pkg::RUN_CFG_OFS: rd_data = run_cfg_q;
      dscg_pkg::IRQ_STAT_OFS: rd_data = {30'h0, irq_stat_q};
      dscg_pkg::IRQ_MASK_OFS: rd_data = {30'h0, irq_mask_q};
      default: rd_hit = 1'b0;
    endcase
  end
  assign stat_read = rd_fire && (rd_addr == dscg_pkg::IRQ_STAT_OFS);

  // Address ready drops while an answer stands, so one read at a time
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b0;
    end else begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !rd_fire;
    end
  end

  // Read answer is captured at the handshake and held until taken
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= dscg_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_data;
      S_AXI_RRESP <= rd_hit ? dscg_pkg::RESP_OKAY : dscg_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // Sticky access fault; a read clears it but a same-cycle event still lands
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      irq_stat_q[dscg_pkg::IRQ_FAULT_BIT] <= dscg_pkg::IRQ_RESET[dscg_pkg::IRQ_FAULT_BIT];
    end else begin
      irq_stat_q[dscg_pkg::IRQ_FAULT_BIT] <= fault_evt ||
        (irq_stat_q[dscg_pkg::IRQ_FAULT_BIT] && !stat_read);
    end
  end

  // Sticky power mode change, cleared the same way so no change is lost
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      irq_stat_q[dscg_pkg::IRQ_MODE_BIT] <= dscg_pkg::IRQ_RESET[dscg_pkg::IRQ_MODE_BIT];
    end else begin
      irq_stat_q[dscg_pkg::IRQ_MODE_BIT] <= mode_evt ||
        (irq_stat_q[dscg_pkg::IRQ_MODE_BIT] && !stat_read);
    end
  end

  // Level interrupt from a flop
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_stat_q & irq_mask_q);
    end
  end

endmodule

// [verif/dscg_chk.sv]
`timescale 1ns/1ps
module dscg_chk (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic UNIT_ACC_VALID,
  input wire logic [2:0] UNIT_ACC_SEL,
  input wire logic UNIT_ACC_FAULT,
  input wire logic [7:0] UNIT_CLK_EN,
  input wire logic IRQ
);
  logic [11:0] rd_addr_q;
  logic rd_gate;
  logic rd_map;
  // Last read address, so the returned word can be judged by its target
  always_ff @(posedge CLK_SYS) begin
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rd_addr_q <= S_AXI_ARADDR[11:0];
    end
  end
  // Classify the read in flight
  assign rd_gate = rd_addr_q inside {dscg_pkg::RUN_GATE_OFS, dscg_pkg::SLEEP_GATE_OFS,
                                     dscg_pkg::DEEP_GATE_OFS};
  assign rd_map = rd_gate || rd_addr_q inside {dscg_pkg::RUN_CFG_OFS, dscg_pkg::IRQ_STAT_OFS,
                                               dscg_pkg::IRQ_MASK_OFS};
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  a_gated_fault: assert property (UNIT_ACC_VALID && !UNIT_CLK_EN[UNIT_ACC_SEL] |=> UNIT_ACC_FAULT)
    else $error("access to gated unit gave no fault");
  a_clocked_ok: assert property (UNIT_ACC_VALID && UNIT_CLK_EN[UNIT_ACC_SEL] |=> !UNIT_ACC_FAULT)
    else $error("access to clocked unit faulted");
  a_fault_cause: assert property (UNIT_ACC_FAULT |-> $past(UNIT_ACC_VALID))
    else $error("fault without access");
  a_reset_gates: assert property ($past(RST) |-> UNIT_CLK_EN == 8'h00 && !IRQ)
    else $error("enables not clear after reset");
  a_gate_reserved: assert property (S_AXI_RVALID && rd_gate |-> (S_AXI_RDATA & ~dscg_pkg::GATE_WMASK) == 32'h0)
    else $error("reserved gate bits read nonzero");
  a_unmapped_err: assert property (S_AXI_RVALID && !rd_map |-> S_AXI_RRESP == dscg_pkg::RESP_SLVERR && S_AXI_RDATA == 32'h0)
    else $error("unmapped read not refused");
  a_read_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer dropped early");
  a_write_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write answer dropped early");
  // Main scenarios reached
  cover property (UNIT_ACC_FAULT);
  cover property (IRQ);
  cover property (S_AXI_RVALID && !rd_map);
endmodule
bind dscg_top dscg_chk dscg_chk_inst (
  .CLK_SYS(CLK_SYS),
  .RST(RST),
  .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RRESP(S_AXI_RRESP),
  .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY),
  .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY),
  .UNIT_ACC_VALID(UNIT_ACC_VALID),
  .UNIT_ACC_SEL(UNIT_ACC_SEL),
  .UNIT_ACC_FAULT(UNIT_ACC_FAULT),
  .UNIT_CLK_EN(UNIT_CLK_EN),
  .IRQ(IRQ)
);

// [verif/tb_top.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module tb_top;
  logic CLK_SYS, RST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
  logic SLEEP_REQ, DEEP_SLEEP_REQ, UNIT_ACC_VALID, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
  logic S_AXI_ARREADY, S_AXI_RVALID, UNIT_ACC_FAULT, IRQ;
  logic [31:0] S_AXI_AWADDR, S_AXI_WDATA, S_AXI_ARADDR, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB;
  logic [2:0] UNIT_ACC_SEL;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [7:0] UNIT_CLK_EN;
  int errors, checks;
  int pos [8] = '{dscg_pkg::UARTA_BIT, dscg_pkg::UARTB_BIT, dscg_pkg::SSP_BIT, dscg_pkg::ENC_BIT,
                  dscg_pkg::TMRA_BIT, dscg_pkg::TMRB_BIT, dscg_pkg::TMRC_BIT, dscg_pkg::COMP_BIT};
  logic [11:0] ofs [6] = '{dscg_pkg::RUN_GATE_OFS, dscg_pkg::SLEEP_GATE_OFS,
                           dscg_pkg::DEEP_GATE_OFS, dscg_pkg::RUN_CFG_OFS,
                           dscg_pkg::IRQ_STAT_OFS, dscg_pkg::IRQ_MASK_OFS};
  dscg_top dscg_top_inst (
    .CLK_SYS(CLK_SYS),
    .RST(RST),
    .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB),
    .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP),
    .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY),
    .SLEEP_REQ(SLEEP_REQ),
    .DEEP_SLEEP_REQ(DEEP_SLEEP_REQ),
    .UNIT_ACC_VALID(UNIT_ACC_VALID),
    .UNIT_ACC_SEL(UNIT_ACC_SEL),
    .UNIT_ACC_FAULT(UNIT_ACC_FAULT),
    .UNIT_CLK_EN(UNIT_CLK_EN),
    .IRQ(IRQ)
  );
  // Free-running system clock
  always #5 CLK_SYS = ~CLK_SYS;
  task automatic complete_run();
    if (errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Write one word; address and data are offered together and each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge CLK_SYS);
    S_AXI_AWADDR <= {20'h0, a};
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
    end while (S_AXI_BVALID !== 1'b1);
    S_AXI_BREADY <= 1'b0;
    `CHK("bresp", er, S_AXI_BRESP)
  endtask
  // Read one word and judge data and response
  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge CLK_SYS);
    S_AXI_ARADDR <= {20'h0, a};
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 1'b0;
    end while (S_AXI_RVALID !== 1'b1);
    S_AXI_RREADY <= 1'b0;
    `CHK("rdata", ed, S_AXI_RDATA)
    `CHK("rresp", er, S_AXI_RRESP)
  endtask
  // One-cycle peripheral access; the fault answer stands in the following cycle only
  task automatic acc(input logic [2:0] sel, input logic ef);
    @(posedge CLK_SYS);
    UNIT_ACC_SEL <= sel;
    UNIT_ACC_VALID <= 1'b1;
    @(posedge CLK_SYS);
    UNIT_ACC_VALID <= 1'b0;
    @(posedge CLK_SYS);
    `CHK("fault", ef, UNIT_ACC_FAULT)
  endtask
  task automatic t_reset();
    for (int i = 0; i < 6; i++) rd(ofs[i], 32'h0000_0000, dscg_pkg::RESP_OKAY);
    `CHK("en_reset", 8'h00, UNIT_CLK_EN)
  endtask
  // Walk each gate bit alone so a swapped position shows on the enables
  task automatic t_fields();
    wr(dscg_pkg::RUN_GATE_OFS, 32'hFFFF_FFFF, dscg_pkg::RESP_OKAY);
    rd(dscg_pkg::RUN_GATE_OFS, 32'h0107_0113, dscg_pkg::RESP_OKAY);
    // Read-modify-write that keeps reserved bits as read, then a low-byte-only write
    wr(dscg_pkg::RUN_GATE_OFS, 32'h0107_0112, dscg_pkg::RESP_OKAY);
    rd(dscg_pkg::RUN_GATE_OFS, 32'h0107_0112, dscg_pkg::RESP_OKAY);
    S_AXI_WSTRB <= 4'h1;
    wr(dscg_pkg::RUN_GATE_OFS, 32'h0000_0000, dscg_pkg::RESP_OKAY);
    S_AXI_WSTRB <= 4'hF;
    rd(dscg_pkg::RUN_GATE_OFS, 32'h0107_0100, dscg_pkg::RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      wr(dscg_pkg::RUN_GATE_OFS, 32'h1 << pos[i], dscg_pkg::RESP_OKAY);
      repeat (3) @(posedge CLK_SYS);
      `CHK("en_bit", 8'h01 << i, UNIT_CLK_EN)
    end
    wr(12'h300, 32'hFFFF_FFFF, dscg_pkg::RESP_SLVERR);
    rd(12'h300, 32'h0000_0000, dscg_pkg::RESP_SLVERR);
  endtask
  task automatic t_fault();
    wr(dscg_pkg::RUN_GATE_OFS, 32'h0000_0001, dscg_pkg::RESP_OKAY);
    wr(dscg_pkg::IRQ_MASK_OFS, 32'h0000_0001, dscg_pkg::RESP_OKAY);
    repeat (3) @(posedge CLK_SYS);
    for (int i = 0; i < 8; i++) acc(3'(i), logic'(i != 0));
    repeat (2) @(posedge CLK_SYS);
    `CHK("irq_on", 1'b1, IRQ)
    rd(dscg_pkg::IRQ_STAT_OFS, 32'h0000_0001, dscg_pkg::RESP_OKAY);
    repeat (3) @(posedge CLK_SYS);
    `CHK("irq_clr", 1'b0, IRQ)
    wr(dscg_pkg::IRQ_MASK_OFS, 32'h0000_0000, dscg_pkg::RESP_OKAY);
    acc(3'h3, 1'b1);
    repeat (3) @(posedge CLK_SYS);
    `CHK("irq_mask", 1'b0, IRQ)
    rd(dscg_pkg::IRQ_STAT_OFS, 32'h0000_0001, dscg_pkg::RESP_OKAY);
  endtask
  // Mode copies: run copy holds until auto gate is set, deep request wins
  task automatic t_modes();
    wr(dscg_pkg::SLEEP_GATE_OFS, 32'h1 << dscg_pkg::SSP_BIT, dscg_pkg::RESP_OKAY);
    wr(dscg_pkg::DEEP_GATE_OFS, 32'h1 << dscg_pkg::ENC_BIT, dscg_pkg::RESP_OKAY);
    @(posedge CLK_SYS);
    SLEEP_REQ <= 1'b1;
    repeat (4) @(posedge CLK_SYS);
    `CHK("en_noauto", 8'h01, UNIT_CLK_EN)
    wr(dscg_pkg::RUN_CFG_OFS, 32'h0800_0000, dscg_pkg::RESP_OKAY);
    repeat (3) @(posedge CLK_SYS);
    `CHK("en_sleep", 8'h04, UNIT_CLK_EN)
    DEEP_SLEEP_REQ <= 1'b1;
    repeat (4) @(posedge CLK_SYS);
    `CHK("en_deep", 8'h08, UNIT_CLK_EN)
    rd(dscg_pkg::IRQ_STAT_OFS, 32'h0000_0002, dscg_pkg::RESP_OKAY);
    SLEEP_REQ <= 1'b0;
    DEEP_SLEEP_REQ <= 1'b0;
    repeat (4) @(posedge CLK_SYS);
    `CHK("en_run", 8'h01, UNIT_CLK_EN)
  endtask
  // Main sequence, reset held for five cycles
  initial begin
    {CLK_SYS, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    {SLEEP_REQ, DEEP_SLEEP_REQ, UNIT_ACC_VALID, UNIT_ACC_SEL} = '0;
    {S_AXI_AWADDR, S_AXI_WDATA, S_AXI_ARADDR} = '0;
    S_AXI_WSTRB = 4'hF;
    RST = 1'b1;
    repeat (5) @(posedge CLK_SYS);
    RST <= 1'b0;
    t_reset();
    t_fields();
    t_fault();
    t_modes();
    // A reset in mid-run must clear every copy, the config and the status again
    RST <= 1'b1;
    repeat (5) @(posedge CLK_SYS);
    RST <= 1'b0;
    t_reset();
    complete_run();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    errors++;
    complete_run();
  end
endmodule
